// ### logic/mif_defs.vh
// Register offsets, field positions, reset values and timing constants
// of the motion interrupt and sample buffer logic.
// Assumes inclusion by bare name from the design files only.
`ifndef MIF_DEFS_VH
`define MIF_DEFS_VH

// ==========================================================
// Register offsets
`define MIF_A_KNOCK_THR   8'h1d
`define MIF_A_KNOCK_MAX   8'h21
`define MIF_A_KNOCK_LAT   8'h22
`define MIF_A_KNOCK_WIN   8'h23
`define MIF_A_MOTION_THR  8'h24
`define MIF_A_STILL_THR   8'h25
`define MIF_A_STILL_TIME  8'h26
`define MIF_A_AXIS_PART   8'h27
`define MIF_A_DROP_THR    8'h28
`define MIF_A_DROP_TIME   8'h29
`define MIF_A_IRQ_EN      8'h2e
`define MIF_A_IRQ_ROUTE   8'h2f
`define MIF_A_IRQ_SRC     8'h30
`define MIF_A_OUT_FMT     8'h31
`define MIF_A_X_LOW       8'h32
`define MIF_A_Z_HIGH      8'h37
`define MIF_A_BUF_CTL     8'h38
`define MIF_A_ORIENT_CFG  8'h3b
`define MIF_A_ORIENT_STAT 8'h3c

// ==========================================================
// Flag positions in the enable, routing and source registers
`define MIF_F_READY   7
`define MIF_F_KNOCK   6
`define MIF_F_DOUBLE  5
`define MIF_F_MOTION  4
`define MIF_F_STILL   3
`define MIF_F_DROP    2
`define MIF_F_WMARK   1
`define MIF_F_OVERRUN 0

// ==========================================================
// Control field positions
`define MIF_B_INVERT      5
`define MIF_B_DIM3D       3
`define MIF_B_ORIENT_EN   6
`define MIF_B_ORIENT_MAP  5
`define MIF_B_MODE_HI     7
`define MIF_B_MODE_LO     6
`define MIF_B_LEVEL_HI    4
`define MIF_B_MOTION_X    6
`define MIF_B_STILL_X     2

// ==========================================================
// Buffer modes and reset values
`define MIF_MODE_BYPASS 2'h0
`define MIF_MODE_FILL   2'h1
`define MIF_MODE_STREAM 2'h2
`define MIF_MODE_TRIG   2'h3
`define MIF_RST_REG     8'h00

// ==========================================================
// Timing: drop time step and stillness time step
`define MIF_CLK_PERIOD_NS 4
`define MIF_DROP_STEP_NS  5000000
`define MIF_DROP_STEP_CYC (`MIF_DROP_STEP_NS / `MIF_CLK_PERIOD_NS)
`define MIF_STILL_STEPS   200

`endif

// ### logic/mif_buf_mem.v
// Sample buffer storage: one write port, one read port.
// Assumes the caller keeps addresses in range; read data is registered.
`timescale 1ns/1ps
`default_nettype none

module mif_buf_mem #(
  parameter WIDTH = 48,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,              // System clock
  input wire rst,              // Asynchronous reset, active high
  input wire wr_en,            // Write strobe
  input wire [AW-1:0] waddr,   // Write index
  input wire [WIDTH-1:0] wdata, // Write word
  input wire [AW-1:0] raddr,   // Read index
  output reg [WIDTH-1:0] rdata // Registered read word
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // ==========================================================
  // Storage write, no reset so it maps onto RAM
  always @(posedge clk) begin
    if (wr_en) begin
      mem[waddr] <= wdata;
    end
  end

  // Read register; stale words show until the next edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= {WIDTH{1'b0}};
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // mif_buf_mem
`default_nettype wire

// ### logic/mif_top.v
// Interrupt flags, routing and sample buffer of a three-axis motion sensor.
// Assumes samples and orientation codes come from logic on MCLK and that
// register strobes are single-cycle pulses from the serial front end.
//
// Summary of operation
// - Pins active high; D5 of 0x31 inverts
// - Enable 0x2e gates, routing 0x2f picks pin
// - All functions run together, shared pins
// - Flags latch; data reads or 0x30 clear
// - Ready flag follows unread new data
// - Short knock over threshold sets knock
// - Second knock inside latency/window sets double
// - Any participating axis over threshold sets motion
// - All participating axes still long sets stillness
// - All axes low long sets drop
// - Watermark while count at or above level
// - Overrun: overwrite in bypass, full otherwise
// - Orientation flag on valid-to-other-valid change
// - Dead zone orientations count as invalid
// - D3 of 0x3b picks 2D or 3D
// - 32-level buffer, mode field D7:D6
// - Bypass keeps the buffer empty
// - Fill mode stops at 32, detection continues
// - Stream keeps newest 32, drops oldest
// - Buffer read moves oldest sample to outputs
`timescale 1ns/1ps
`default_nettype none
`include "mif_defs.vh"

module mif_top #(
  parameter DEPTH = 32,
  parameter AW = 5,
  parameter DROP_STEP_CYC = `MIF_DROP_STEP_CYC,
  parameter STILL_STEPS = `MIF_STILL_STEPS
) (
  input wire MCLK,               // System clock, 250 MHz
  input wire RESET,              // Asynchronous reset, active high
  input wire [7:0] REG_ADDR,     // Register index
  input wire REG_WR,             // Write strobe, one cycle
  input wire [7:0] REG_WDATA,    // Write data
  input wire REG_RD,             // Read strobe, one cycle
  output reg [7:0] REG_RDATA,    // Read data, one cycle after strobe
  input wire SAMPLE_VALID,       // New three-axis sample, one cycle
  input wire [15:0] SAMPLE_X,    // X acceleration, twos complement
  input wire [15:0] SAMPLE_Y,    // Y acceleration
  input wire [15:0] SAMPLE_Z,    // Z acceleration
  input wire [2:0] ORIENT_POS,   // Current orientation code
  input wire ORIENT_OK_2D,       // Code valid in 2D set, outside dead zone
  input wire ORIENT_OK_3D,       // Code valid in 3D set, outside dead zone
  output reg IRQ_OUT_A,          // First interrupt pin
  output reg IRQ_OUT_B           // Second interrupt pin
);

  // Magnitude on the threshold scale: |v| / 16, saturated to 8 bits
  function [7:0] mag8;
    input [15:0] v;
    reg [15:0] a;
    begin
      a = v[15] ? (~v + 16'h0001) : v;
      mag8 = (a[15:12] != 4'h0) ? 8'hff : a[11:4];
    end
  endfunction

  // ==========================================================
  // Configuration registers
  reg [7:0] knock_threshold_r, knock_max_time_r, knock_latency_r;
  reg [7:0] knock_window_r, motion_threshold_r, stillness_threshold_r;
  reg [7:0] stillness_time_r, axis_participation_r, drop_threshold_r;
  reg [7:0] drop_time_r, irq_enable_mask_r, irq_routing_r;
  reg [7:0] output_format_r, buffer_control_r, orientation_config_r;

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      knock_threshold_r <= `MIF_RST_REG;
      knock_max_time_r <= `MIF_RST_REG;
      knock_latency_r <= `MIF_RST_REG;
      knock_window_r <= `MIF_RST_REG;
      motion_threshold_r <= `MIF_RST_REG;
      stillness_threshold_r <= `MIF_RST_REG;
      stillness_time_r <= `MIF_RST_REG;
      axis_participation_r <= `MIF_RST_REG;
      drop_threshold_r <= `MIF_RST_REG;
      drop_time_r <= `MIF_RST_REG;
      irq_enable_mask_r <= `MIF_RST_REG;
      irq_routing_r <= `MIF_RST_REG;
      output_format_r <= `MIF_RST_REG;
      buffer_control_r <= `MIF_RST_REG;
      orientation_config_r <= `MIF_RST_REG;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `MIF_A_KNOCK_THR: knock_threshold_r <= REG_WDATA;
        `MIF_A_KNOCK_MAX: knock_max_time_r <= REG_WDATA;
        `MIF_A_KNOCK_LAT: knock_latency_r <= REG_WDATA;
        `MIF_A_KNOCK_WIN: knock_window_r <= REG_WDATA;
        `MIF_A_MOTION_THR: motion_threshold_r <= REG_WDATA;
        `MIF_A_STILL_THR: stillness_threshold_r <= REG_WDATA;
        `MIF_A_STILL_TIME: stillness_time_r <= REG_WDATA;
        `MIF_A_AXIS_PART: axis_participation_r <= REG_WDATA;
        `MIF_A_DROP_THR: drop_threshold_r <= REG_WDATA;
        `MIF_A_DROP_TIME: drop_time_r <= REG_WDATA;
        `MIF_A_IRQ_EN: irq_enable_mask_r <= REG_WDATA;
        `MIF_A_IRQ_ROUTE: irq_routing_r <= REG_WDATA;
        `MIF_A_OUT_FMT: output_format_r <= REG_WDATA;
        `MIF_A_BUF_CTL: buffer_control_r <= REG_WDATA;
        `MIF_A_ORIENT_CFG: orientation_config_r <= REG_WDATA;
        default: ;
      endcase
    end
  end

  wire rd_src = REG_RD && (REG_ADDR == `MIF_A_IRQ_SRC);
  wire rd_last = REG_RD && (REG_ADDR == `MIF_A_Z_HIGH);
  wire [1:0] mode = buffer_control_r[`MIF_B_MODE_HI:`MIF_B_MODE_LO];
  wire bypass = (mode == `MIF_MODE_BYPASS);
  wire [5:0] level = {1'b0, buffer_control_r[`MIF_B_LEVEL_HI:0]};

  // ==========================================================
  // Per-sample magnitudes and comparisons
  wire [7:0] mx = mag8(SAMPLE_X);
  wire [7:0] my = mag8(SAMPLE_Y);
  wire [7:0] mz = mag8(SAMPLE_Z);
  wire over_knock = (mx > knock_threshold_r) || (my > knock_threshold_r) ||
                    (mz > knock_threshold_r);
  wire [2:0] act_part = axis_participation_r[`MIF_B_MOTION_X -: 3];
  wire [2:0] ina_part = axis_participation_r[`MIF_B_STILL_X -: 3];
  wire [2:0] act_hit = {mx > motion_threshold_r, my > motion_threshold_r,
                        mz > motion_threshold_r};
  wire [2:0] ina_low = {mx < stillness_threshold_r,
                        my < stillness_threshold_r,
                        mz < stillness_threshold_r};
  wire all_low = (mx < drop_threshold_r) && (my < drop_threshold_r) &&
                 (mz < drop_threshold_r);
  wire ev_motion = SAMPLE_VALID && ((act_hit & act_part) != 3'h0);
  wire still_now = (ina_part != 3'h0) && ((ina_low | ~ina_part) == 3'h7);

  // ==========================================================
  // Time steps: 5 ms for drop, 1 s for stillness
  reg [31:0] step_cnt_r;
  reg [7:0] sec_cnt_r;
  wire drop_step = (step_cnt_r == DROP_STEP_CYC - 1);
  wire sec_step = drop_step && (sec_cnt_r == STILL_STEPS - 1);
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      step_cnt_r <= 32'h00000000;
      sec_cnt_r <= 8'h00;
    end else if (drop_step) begin
      step_cnt_r <= 32'h00000000;
      sec_cnt_r <= sec_step ? 8'h00 : sec_cnt_r + 8'h01;
    end else begin
      step_cnt_r <= step_cnt_r + 32'h00000001;
    end
  end

  // ==========================================================
  // Knock detection, durations counted in samples
  reg in_knock_r, await_r;
  reg [7:0] knock_len_r;
  reg [8:0] since_r;
  wire knock_end = SAMPLE_VALID && in_knock_r && !over_knock;
  wire ev_knock = knock_end && (knock_len_r < knock_max_time_r);
  wire knock_start = SAMPLE_VALID && !in_knock_r && over_knock;
  wire [8:0] win_end = {1'b0, knock_latency_r} + {1'b0, knock_window_r};
  // second start after latency, inside window
  wire second_ok = await_r && (since_r > {1'b0, knock_latency_r}) &&
                   (since_r <= win_end);
  reg second_r;
  wire ev_double = ev_knock && second_r;
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      in_knock_r <= 1'b0;
      knock_len_r <= 8'h00;
      await_r <= 1'b0;
      since_r <= 9'h000;
      second_r <= 1'b0;
    end else if (SAMPLE_VALID) begin
      in_knock_r <= over_knock;
      if (knock_start) begin
        knock_len_r <= 8'h00;
        second_r <= second_ok;
      end else if (in_knock_r && knock_len_r != 8'hff) begin
        knock_len_r <= knock_len_r + 8'h01;
      end
      if (ev_knock && !second_r) begin
        await_r <= 1'b1;
        since_r <= 9'h000;
      end else if (ev_double || (await_r && since_r > win_end)) begin
        await_r <= 1'b0;
      end else if (await_r && since_r != 9'h1ff) begin
        since_r <= since_r + 9'h001;
      end
    end
  end

  // ==========================================================
  // Stillness and drop timers, one event per quiet period
  reg [8:0] still_t_r, drop_t_r;
  reg still_done_r, drop_done_r, still_q_r, low_q_r;
  // still longer than the stillness time
  wire ev_still = still_q_r && !still_done_r &&
                  (still_t_r > {1'b0, stillness_time_r});
  // all axes low longer than the drop time
  wire ev_drop = low_q_r && !drop_done_r &&
                 (drop_t_r > {1'b0, drop_time_r});
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      still_q_r <= 1'b0;
      low_q_r <= 1'b0;
      still_t_r <= 9'h000;
      drop_t_r <= 9'h000;
      still_done_r <= 1'b0;
      drop_done_r <= 1'b0;
    end else begin
      if (SAMPLE_VALID) begin
        still_q_r <= still_now;
        low_q_r <= all_low;
      end
      if (!still_q_r) begin
        still_t_r <= 9'h000;
        still_done_r <= 1'b0;
      end else begin
        if (sec_step && still_t_r != 9'h1ff) begin
          still_t_r <= still_t_r + 9'h001;
        end
        if (ev_still) begin
          still_done_r <= 1'b1;
        end
      end
      if (!low_q_r) begin
        drop_t_r <= 9'h000;
        drop_done_r <= 1'b0;
      end else begin
        if (drop_step && drop_t_r != 9'h1ff) begin
          drop_t_r <= drop_t_r + 9'h001;
        end
        if (ev_drop) begin
          drop_done_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Orientation change tracking
  // dimension bit picks the valid set
  wire dim3 = orientation_config_r[`MIF_B_DIM3D];
  // dead zone shows up as not valid
  wire orient_ok = dim3 ? ORIENT_OK_3D : ORIENT_OK_2D;
  reg [2:0] last_pos_r;
  reg have_pos_r;
  // only a valid code differing from the last valid one
  wire ev_orient = orient_ok && have_pos_r && (ORIENT_POS != last_pos_r);
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      last_pos_r <= 3'h0;
      have_pos_r <= 1'b0;
    end else if (orient_ok) begin
      last_pos_r <= ORIENT_POS;
      have_pos_r <= 1'b1;
    end
  end

  // ==========================================================
  // Sample buffer control
  reg [AW-1:0] wptr_r, rptr_r;
  reg [AW:0] count_r;
  wire [47:0] mem_rdata;
  wire full = (count_r == DEPTH);
  // stream overwrites the oldest when full
  wire buf_wr = SAMPLE_VALID && !bypass && (!full || mode != `MIF_MODE_FILL);
  wire drop_old = buf_wr && full;
  // reading the last output byte pops one sample
  wire pop = rd_last && !bypass && (count_r != 0) && !drop_old;
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (bypass) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (buf_wr) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop || drop_old) begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (buf_wr && !full && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !buf_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // 32 words of three axes each
  mif_buf_mem #(.WIDTH(48), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(MCLK),
    .rst(RESET),
    .wr_en(buf_wr),
    .waddr(wptr_r),
    .wdata({SAMPLE_Z, SAMPLE_Y, SAMPLE_X}),
    .raddr(rptr_r),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // Bypass output holding registers and unread tracking
  reg [47:0] hold_r;
  reg unread_r;
  wire byp_over = bypass && SAMPLE_VALID && unread_r;
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      hold_r <= 48'h000000000000;
      unread_r <= 1'b0;
    end else if (bypass && SAMPLE_VALID) begin
      hold_r <= {SAMPLE_Z, SAMPLE_Y, SAMPLE_X};
      unread_r <= 1'b1;
    end else if (rd_last || !bypass) begin
      unread_r <= 1'b0;
    end
  end
  wire [47:0] out_word = bypass ? hold_r : mem_rdata;

  // ==========================================================
  // Latched flags; a new event beats a same-cycle clear
  reg [7:0] flags_r;
  reg orient_flag_r;
  reg [7:0] ev;
  always @* begin
    ev = 8'h00;
    ev[`MIF_F_KNOCK] = ev_knock;
    ev[`MIF_F_DOUBLE] = ev_double;
    ev[`MIF_F_MOTION] = ev_motion;
    ev[`MIF_F_STILL] = ev_still;
    ev[`MIF_F_DROP] = ev_drop;
  end
  wire ev_over = bypass ? byp_over :
                 (buf_wr && (full || (count_r == DEPTH - 1 && !pop)));
  // every detector runs regardless of the others
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      flags_r <= 8'h00;
      orient_flag_r <= 1'b0;
    end else begin
      // source read clears the event flags
      flags_r[7:2] <= ev[7:2] | (rd_src ? 6'h00 : flags_r[7:2]);
      flags_r[`MIF_F_OVERRUN] <= ev_over |
                                 (flags_r[`MIF_F_OVERRUN] && !rd_last);
      flags_r[`MIF_F_WMARK] <= 1'b0;
      flags_r[`MIF_F_READY] <= 1'b0;
      orient_flag_r <= ev_orient | (orient_flag_r && !rd_src);
    end
  end

  wire ready = bypass ? unread_r : (count_r != 0);
  // watermark while count at or above level
  wire wmark = !bypass && (level != 6'h00) && (count_r >= level);
  reg [7:0] src;
  always @* begin
    src = flags_r;
    src[`MIF_F_READY] = ready;
    src[`MIF_F_WMARK] = wmark;
  end

  // ==========================================================
  // Interrupt pins
  // enable gates, routing bit 1 selects second pin
  wire [7:0] live = src & irq_enable_mask_r;
  wire o_live = orient_flag_r && orientation_config_r[`MIF_B_ORIENT_EN];
  wire o_map = orientation_config_r[`MIF_B_ORIENT_MAP];
  wire inv = output_format_r[`MIF_B_INVERT];
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      IRQ_OUT_A <= 1'b0;
      IRQ_OUT_B <= 1'b0;
    end else begin
      IRQ_OUT_A <= ((|(live & ~irq_routing_r)) | (o_live && !o_map)) ^ inv;
      IRQ_OUT_B <= ((|(live & irq_routing_r)) | (o_live && o_map)) ^ inv;
    end
  end

  // ==========================================================
  // Read data, registered one cycle after the strobe
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `MIF_A_KNOCK_THR: REG_RDATA <= knock_threshold_r;
        `MIF_A_KNOCK_MAX: REG_RDATA <= knock_max_time_r;
        `MIF_A_KNOCK_LAT: REG_RDATA <= knock_latency_r;
        `MIF_A_KNOCK_WIN: REG_RDATA <= knock_window_r;
        `MIF_A_MOTION_THR: REG_RDATA <= motion_threshold_r;
        `MIF_A_STILL_THR: REG_RDATA <= stillness_threshold_r;
        `MIF_A_STILL_TIME: REG_RDATA <= stillness_time_r;
        `MIF_A_AXIS_PART: REG_RDATA <= axis_participation_r;
        `MIF_A_DROP_THR: REG_RDATA <= drop_threshold_r;
        `MIF_A_DROP_TIME: REG_RDATA <= drop_time_r;
        `MIF_A_IRQ_EN: REG_RDATA <= irq_enable_mask_r;
        `MIF_A_IRQ_ROUTE: REG_RDATA <= irq_routing_r;
        `MIF_A_IRQ_SRC: REG_RDATA <= src;
        `MIF_A_OUT_FMT: REG_RDATA <= output_format_r;
        `MIF_A_X_LOW: REG_RDATA <= out_word[7:0];
        `MIF_A_X_LOW + 8'h01: REG_RDATA <= out_word[15:8];
        `MIF_A_X_LOW + 8'h02: REG_RDATA <= out_word[23:16];
        `MIF_A_X_LOW + 8'h03: REG_RDATA <= out_word[31:24];
        `MIF_A_X_LOW + 8'h04: REG_RDATA <= out_word[39:32];
        `MIF_A_Z_HIGH: REG_RDATA <= out_word[47:40];
        `MIF_A_BUF_CTL: REG_RDATA <= buffer_control_r;
        `MIF_A_ORIENT_CFG: REG_RDATA <= orientation_config_r;
        `MIF_A_ORIENT_STAT: REG_RDATA <= {4'h0, orient_flag_r, last_pos_r};
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

endmodule // mif_top
`default_nettype wire

// ### sim/mif_top_props.sv
// Checker: pin and read-port relations of mif_top.
// Assumes it is bound to mif_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mif_top_props (
  input wire logic MCLK, // Clock
  input wire logic RESET, // Async reset
  input wire logic [7:0] REG_ADDR, // Index
  input wire logic REG_WR, // Write strobe
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic REG_RD, // Read strobe
  input wire logic [7:0] REG_RDATA, // Read data
  input wire logic SAMPLE_VALID, // New sample
  input wire logic IRQ_OUT_A, // Pin A
  input wire logic IRQ_OUT_B // Pin B
);
  // ========
  // Shadow copies of control writes; unread tracks bypass data
  logic [7:0] en_r, rt_r, fmt_r, bc_r, oc_r;
  logic un_r;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      {en_r, rt_r, fmt_r, bc_r, oc_r} <= 40'h0;
      un_r <= 1'b0;
    end else begin
      if (REG_WR && REG_ADDR == 8'h2e) en_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h2f) rt_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h31) fmt_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h38) bc_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h3b) oc_r <= REG_WDATA;
      if (SAMPLE_VALID) un_r <= 1'b1;
      // Clearing last keeps the checker conservative on a tie
      if ((REG_RD && REG_ADDR == 8'h37) || (REG_WR && REG_ADDR == 8'h38))
        un_r <= 1'b0;
    end
  end
  wire byp = bc_r[7:6] == 2'h0;
  wire inv = fmt_r[5];
  // ========
  // Properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  reset_quiet_a: assert property (
    $fell(RESET) |-> !IRQ_OUT_A && !IRQ_OUT_B) else $error("pin after reset");
  idle_level_a: assert property (
    en_r == 8'h00 && !oc_r[6] && $stable(en_r) && $stable(fmt_r)
    && $stable(oc_r) |-> IRQ_OUT_A == inv && IRQ_OUT_B == inv)
    else $error("pin active with nothing enabled");
  b_unrouted_a: assert property (
    rt_r == 8'h00 && !oc_r[5] && $stable(rt_r) && $stable(oc_r)
    && $stable(fmt_r) |-> IRQ_OUT_B == inv) else $error("pin B unrouted");
  a_unrouted_a: assert property (
    rt_r == 8'hff && oc_r[5] && $stable(rt_r) && $stable(oc_r)
    && $stable(fmt_r) |-> IRQ_OUT_A == inv) else $error("pin A unrouted");
  ready_set_a: assert property (
    SAMPLE_VALID && en_r[7] && !rt_r[7] && byp |-> ##[1:3] IRQ_OUT_A != inv)
    else $error("ready not raised");
  ready_clr_a: assert property (
    REG_RD && REG_ADDR == 8'h37 && (en_r & ~rt_r) == 8'h80 && !oc_r[6]
    && byp && !SAMPLE_VALID ##1 !SAMPLE_VALID [*2] |-> ##[0:1]
    IRQ_OUT_A == inv) else $error("ready not cleared");
  overrun_byp_a: assert property (
    SAMPLE_VALID && un_r && en_r[0] && rt_r[0] && byp
    |-> ##[1:3] IRQ_OUT_B != inv) else $error("overrun not raised");
  rdata_hold_a: assert property (
    !REG_RD && !$past(REG_RD) |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  cover property (SAMPLE_VALID && un_r && byp);
  cover property (REG_RD && REG_ADDR == 8'h37 && !byp);
  cover property (IRQ_OUT_B && oc_r[5]);
endmodule // mif_top_props
bind mif_top mif_top_props mif_top_props_inst (.MCLK(MCLK), .RESET(RESET),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SAMPLE_VALID(SAMPLE_VALID),
  .IRQ_OUT_A(IRQ_OUT_A), .IRQ_OUT_B(IRQ_OUT_B));
`default_nettype wire

// ### sim/mif_host_model.sv
// Host processor model: drives the register strobes of mif_top.
// Assumes strobes are sampled on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module mif_host_model (
  input wire logic clk, // System clock
  output logic [7:0] addr, // Register index
  output logic wr, // Write strobe
  output logic [7:0] wdata, // Write data
  output logic rd // Read strobe
);
  // ========
  // Idle bus at time zero
  initial {addr, wr, wdata, rd} = 18'h0;
  // Released lines show the inverse, so stale values never match
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk);
    {addr, wdata, wr} = {~a, ~d, 1'b0};
  endtask
  // One idle cycle after each read gives the buffer time to pop
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    @(negedge clk);
    {addr, rd} = {~a, 1'b0};
    @(negedge clk);
  endtask
  task automatic setup(input logic [7:0] rt, input logic [7:0] en);
    wr_reg(8'h2e, 8'h00);
    wr_reg(8'h2f, rt);
    wr_reg(8'h2e, en);
  endtask
endmodule // mif_host_model
`default_nettype wire

// ### sim/mif_top_tb_top.sv
// Testbench of mif_top: host model drives registers, bench drives samples.
// Assumes the design, host model and bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module mif_top_tb_top;
  logic MCLK, RESET, REG_WR, REG_RD, SAMPLE_VALID, IRQ_OUT_A, IRQ_OUT_B;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  logic [15:0] SAMPLE_X, SAMPLE_Y, SAMPLE_Z, e;
  logic [2:0] ORIENT_POS = 3'h0;
  logic ORIENT_OK_2D = 1'b0, ORIENT_OK_3D = 1'b0, rd_p1, rd_p2;
  int failures = 0, checked = 0, cycles = 0;
  logic [31:0] seed = 32'd3008;
  logic [15:0] exp_q[$];
  logic [47:0] smp_q[$];
  logic [7:0] ra [16] = '{8'h1d, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
    8'h27, 8'h28, 8'h29, 8'h2e, 8'h2f, 8'h31, 8'h38, 8'h3b, 8'h00};
  mif_top #(.DROP_STEP_CYC(10), .STILL_STEPS(3)) mif_top_inst (.MCLK(MCLK),
    .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_X(SAMPLE_X), .SAMPLE_Y(SAMPLE_Y),
    .SAMPLE_Z(SAMPLE_Z), .ORIENT_POS(ORIENT_POS),
    .ORIENT_OK_2D(ORIENT_OK_2D), .ORIENT_OK_3D(ORIENT_OK_3D),
    .IRQ_OUT_A(IRQ_OUT_A), .IRQ_OUT_B(IRQ_OUT_B));
  mif_host_model mif_host_model_inst (.clk(MCLK), .addr(REG_ADDR),
    .wr(REG_WR), .wdata(REG_WDATA), .rd(REG_RD));
  // ========
  // Clock, read-answer monitor and hang guard
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    {rd_p2, rd_p1} <= {rd_p1, REG_RD};
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // Answer is settled two falling edges after the strobe edge
  always @(negedge MCLK) begin
    if (rd_p2 === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(REG_RDATA & e[15:8], e[7:0])
    end
  end
  // ========
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd_exp(input logic [7:0] a, m, v);
    exp_q.push_back({m, v & m});
    mif_host_model_inst.rd_reg(a);
  endtask
  task automatic pins(input logic [1:0] v);
    repeat (3) @(negedge MCLK);
    `CHK({IRQ_OUT_A, IRQ_OUT_B}, v)
  endtask
  // Model of what the buffer or output registers must hold
  task automatic put(input logic [1:0] m);
    logic [47:0] s;
    s = {16'(rnd()), rnd()};
    @(negedge MCLK);
    {SAMPLE_Z, SAMPLE_Y, SAMPLE_X, SAMPLE_VALID} = {s, 1'b1};
    @(negedge MCLK);
    SAMPLE_VALID = 1'b0;
    if (m == 2'h0) smp_q.delete();
    if (m != 2'h1 || smp_q.size() < 32) smp_q.push_back(s);
    if (smp_q.size() > 32) smp_q.delete(0);
  endtask
  task automatic pop();
    logic [47:0] s = smp_q.pop_front();
    for (int i = 0; i < 6; i++)
      rd_exp(8'h32 + 8'(i), 8'hff, s[8*i +: 8]);
  endtask
  task automatic orient(input logic [2:0] p, input logic [1:0] ok);
    @(negedge MCLK);
    {ORIENT_POS, ORIENT_OK_3D, ORIENT_OK_2D} = {p, ok};
  endtask
  // ========
  // Main sequence
  initial begin
    logic [7:0] d;
    {RESET, SAMPLE_VALID, SAMPLE_X, SAMPLE_Y, SAMPLE_Z} = 50'h2_0000_0000_0000;
    repeat (10) @(posedge MCLK);
    @(negedge MCLK) RESET = 1'b0;
    foreach (ra[i]) rd_exp(ra[i], 8'hff, 8'h00);
    for (int i = 0; i < 10; i++) begin
      d = 8'(rnd());
      mif_host_model_inst.wr_reg(ra[i], d);
      rd_exp(ra[i], 8'hff, d);
      mif_host_model_inst.wr_reg(ra[i], 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      mif_host_model_inst.wr_reg(8'h38, {2'(m), 6'h05});
      rd_exp(8'h38, 8'hff, {2'(m), 6'h05});
    end
    mif_host_model_inst.wr_reg(8'h38, 8'h00);
    mif_host_model_inst.setup(8'h01, 8'h81);
    put(2'h0);
    pins(2'b10);
    put(2'h0);
    pins(2'b11);
    rd_exp(8'h30, 8'h81, 8'h81);
    pop();
    pins(2'b00);
    mif_host_model_inst.wr_reg(8'h31, 8'h20);
    pins(2'b11);
    mif_host_model_inst.wr_reg(8'h31, 8'h00);
    mif_host_model_inst.setup(8'h00, 8'h03);
    mif_host_model_inst.wr_reg(8'h38, 8'h45);
    repeat (4) put(2'h1);
    pins(2'b00);
    repeat (29) put(2'h1);
    rd_exp(8'h30, 8'h03, 8'h03);
    repeat (27) pop();
    pins(2'b10);
    pop();
    pins(2'b00);
    repeat (4) pop();
    mif_host_model_inst.wr_reg(8'h38, 8'h80);
    repeat (34) put(2'h2);
    repeat (32) pop();
    mif_host_model_inst.wr_reg(8'h38, 8'h00);
    mif_host_model_inst.setup(8'h00, 8'h00);
    mif_host_model_inst.wr_reg(8'h3b, 8'h40);
    orient(3'h1, 2'b01);
    rd_exp(8'h30, 8'hff, 8'h00);
    orient(3'h2, 2'b01);
    pins(2'b10);
    rd_exp(8'h30, 8'hff, 8'h00);
    pins(2'b00);
    orient(3'h3, 2'b00);
    orient(3'h2, 2'b01);
    pins(2'b00);
    mif_host_model_inst.wr_reg(8'h2f, 8'hff);
    mif_host_model_inst.wr_reg(8'h3b, 8'h68);
    orient(3'h4, 2'b01);
    pins(2'b00);
    orient(3'h5, 2'b10);
    pins(2'b01);
    mif_host_model_inst.wr_reg(8'h27, 8'h70);
    put(2'h0);
    rd_exp(8'h30, 8'h10, 8'h10);
    wrap_up();
  end
endmodule // mif_top_tb_top
`default_nettype wire
